//--- pccr_cfg.svh
// Offsets, field positions, reset values and timing counts for the bank.
`ifndef PCCR_CFG_SVH
`define PCCR_CFG_SVH
`define PCCR_OFF_OPTION      10'h200
`define PCCR_OFF_STATUS      10'h202
`define PCCR_OFF_PINREP      10'h204
`define PCCR_OPT_SRST_BIT    7
`define PCCR_OPT_LEVEL_BIT   6
`define PCCR_ST_CHANGED_BIT  7
`define PCCR_ST_CHANGE_SIGNAL_ENABLE_BIT   6
`define PCCR_ST_IO8_BIT      5
`define PCCR_ST_PWRDN_BIT    2
`define PCCR_ST_INT_BIT      1
`define PCCR_PR_RCHG_BIT     5
`define PCCR_PR_WCHG_BIT     4
`define PCCR_PR_RDY_BIT      1
`define PCCR_PR_WP_BIT       0
`define PCCR_RST_OPTION      8'h00
`define PCCR_RST_STATUS      8'h00
`define PCCR_PR_ONES         8'h0C
`define PCCR_PWR_SETTLE_NS   200
`define PCCR_PWR_SETTLE_CYC  (((`PCCR_PWR_SETTLE_NS) + 49) / 50)
`define PCCR_IDLE_CYC        1000
`endif

//--- pccr_host_model.sv
// Socket controller model that makes byte accesses to attribute memory.
module pccr_host_model (
   input  wire logic       i_core_clk,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rdata_oe,
   output logic            o_reg_n,
   output logic            o_ce1_n,
   output logic            o_oe_n,
   output logic            o_we_n,
   output logic [9:0]      o_addr,
   output logic [7:0]      o_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {o_reg_n, o_ce1_n, o_oe_n, o_we_n} = 4'hF;
      o_addr = 10'h3FF;
      o_wdata = 8'hFF;
   end
   // -------------------------------------------------------------------
   // Access cycles
   // -------------------------------------------------------------------
   // Released lines show inverted leftovers so stale values never match.
   task automatic rel(input logic [9:0] a, input logic [7:0] d);
      #5;
      {o_reg_n, o_ce1_n, o_oe_n, o_we_n} = 4'hF;
      o_addr = ~a;
      o_wdata = ~d;
      repeat (4) @(posedge i_core_clk);
      #5;
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      #5;
      o_addr = a;
      o_wdata = d;
      {o_reg_n, o_ce1_n, o_oe_n, o_we_n} = 4'h2;
      repeat (6) @(posedge i_core_clk);
      rel(a, d);
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d,
                     output logic oe);
      @(posedge i_core_clk);
      #5;
      o_addr = a;
      {o_reg_n, o_ce1_n, o_oe_n, o_we_n} = 4'h1;
      repeat (6) @(posedge i_core_clk);
      d = i_rdata;
      oe = i_rdata_oe;
      rel(a, 8'h00);
   endtask
endmodule

//--- pccr_pkg.sv
// Types shared by the card configuration register bank.
package pccr_pkg;
   typedef enum logic [1:0] {
      PCCR_MODE_MEM  = 2'b00,
      PCCR_MODE_IO16 = 2'b01,
      PCCR_MODE_PRI  = 2'b10,
      PCCR_MODE_SEC  = 2'b11
   } pccr_mode_e;
   typedef enum logic [1:0] {
      PCCR_PWR_ACTIVE = 2'b00,
      PCCR_PWR_TO_DN  = 2'b01,
      PCCR_PWR_DOWN   = 2'b10,
      PCCR_PWR_TO_UP  = 2'b11
   } pccr_pwr_e;
endpackage

//--- pccr_regs.sv
// Card configuration register bank: option, status and pin replacement.
// Functional notes
// - Soft reset bit holds device in reset
// - Clearing leaves device unconfigured; resets clear it; here the clearing write loads its own config index
// - Soft reset counts as hard reset
// - Level select: one level, zero pulse
// - Config index resets zero, selects mode
// - Changed reads one when any latch set
// - Status change pin low when changed, enabled
// - Status change pin high when not enabled
// - Eight bit request stored, has no effect
// - Power request change shows busy until reached
// - Idle powers down; command powers up
// - Pending bit follows internal request
// - Pending reads zero when interrupts disabled
// - Ready latch sets on ready state change
// - Write protect latch never self-sets
// - Ready state bit reads internal ready
// - Write protect state reads zero
// - Latch writes gated by mask bits
`include "pccr_cfg.svh"
module pccr_regs (
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   input  wire logic              i_reg_n,
   input  wire logic              i_ce1_n,
   input  wire logic              i_oe_n,
   input  wire logic              i_we_n,
   input  wire logic [9:0]        i_addr,
   input  wire logic [7:0]        i_wdata,
   input  wire logic              i_drive_ready,
   input  wire logic              i_drive_irq,
   input  wire logic              i_irq_enable_n,
   input  wire logic              i_cmd_strobe,
   output logic      [7:0]        o_rdata,
   output logic                   o_rdata_oe,
   output logic                   o_hard_reset,
   output logic                   o_level_irq_select,
   output pccr_pkg::pccr_mode_e   o_mode,
   output logic                   o_io_configured,
   output logic                   o_status_change_pin_n,
   output logic                   o_ready_busy,
   output logic                   o_powered_down
);
   import pccr_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers and access decode
   // ----------------------------------------------------------------
   logic [14:0] s1_q, s2_q, s1_d, s2_d;
   logic [7:0]  wd1_q, wd2_q, wd1_d, wd2_d;
   logic [7:0]  wdat;
   logic        wr_prev_q, wr_prev_d;
   logic        rdy_prev_q, rdy_prev_d;
   logic        rd_act, wr_act, wr_pulse;
   logic        rdy_int;

   always_comb begin
      s1_d = {i_reg_n, i_ce1_n, i_oe_n, i_we_n, i_addr, 1'b0};
      s2_d = s1_q;
      wd1_d = i_wdata;
      wd2_d = wd1_q;
      rd_act = !s2_q[14] && !s2_q[13] && !s2_q[12] && s2_q[11];
      wr_act = !s2_q[14] && !s2_q[13] && s2_q[12] && !s2_q[11];
      wr_pulse = wr_act && !wr_prev_q;
      wr_prev_d = wr_act;
   end

   // Strobes, address and write data pass a double flop before any decode
   // reads them, so a write is taken on data that travelled with its strobe.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= 15'h7800;
         s2_q <= 15'h7800;
         wd1_q <= 8'h00;
         wd2_q <= 8'h00;
         wr_prev_q <= 1'b0;
         rdy_prev_q <= 1'b1;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         wd1_q <= wd1_d;
         wd2_q <= wd2_d;
         wr_prev_q <= wr_prev_d;
         rdy_prev_q <= rdy_prev_d;
      end
   end

   function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
      hit = (a == off);
   endfunction

   logic [9:0] addr;
   assign addr = s2_q[10:1];
   assign wdat = wd2_q;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] opt_q, opt_d;
   logic       sig_q, sig_d, io8_q, io8_d, pdn_q, pdn_d;
   logic       rchg_q, rchg_d, wchg_q, wchg_d;
   logic       soft_rst;

   assign soft_rst = opt_q[`PCCR_OPT_SRST_BIT];

   always_comb begin
      opt_d = opt_q;
      sig_d = sig_q;
      io8_d = io8_q;
      pdn_d = pdn_q;
      rchg_d = rchg_q;
      wchg_d = wchg_q;
      rdy_prev_d = rdy_int;
      if (wr_pulse && hit(addr, `PCCR_OFF_OPTION)) begin
         opt_d = wdat;
      end
      if (soft_rst) begin
         // The bit itself survives; only the rest is held in reset.
         sig_d = 1'b0;
         io8_d = 1'b0;
         pdn_d = 1'b0;
         opt_d[6:0] = (wr_pulse && hit(addr, `PCCR_OFF_OPTION)) ?
                      wdat[6:0] : 7'h00;
      end else if (wr_pulse && hit(addr, `PCCR_OFF_STATUS)) begin
         sig_d = wdat[`PCCR_ST_CHANGE_SIGNAL_ENABLE_BIT];
         io8_d = wdat[`PCCR_ST_IO8_BIT];
         pdn_d = wdat[`PCCR_ST_PWRDN_BIT];
      end
      if (!soft_rst && wr_pulse && hit(addr, `PCCR_OFF_PINREP)) begin
         if (wdat[`PCCR_PR_RDY_BIT])
            rchg_d = wdat[`PCCR_PR_RCHG_BIT];
         if (wdat[`PCCR_PR_WP_BIT])
            wchg_d = wdat[`PCCR_PR_WCHG_BIT];
      end
      // A hardware change in the write cycle wins over the host clear.
      if (rdy_int != rdy_prev_q)
         rchg_d = 1'b1;
      // Write protect state is constant, so its latch never self-sets.
      wchg_d = wchg_d;
      if (soft_rst) begin
         rchg_d = 1'b0;
         wchg_d = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         opt_q <= `PCCR_RST_OPTION;
         sig_q <= 1'b0;
         io8_q <= 1'b0;
         pdn_q <= 1'b0;
         rchg_q <= 1'b0;
         wchg_q <= 1'b0;
      end else begin
         opt_q <= opt_d;
         sig_q <= sig_d;
         io8_q <= io8_d;
         pdn_q <= pdn_d;
         rchg_q <= rchg_d;
         wchg_q <= wchg_d;
      end
   end

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   pccr_pwr_e  pwr_q, pwr_d;
   logic [9:0] cnt_q, cnt_d;
   logic       want_dn;

   always_comb begin
      pwr_d = pwr_q;
      cnt_d = cnt_q;
      want_dn = pdn_q;
      case (pwr_q)
         PCCR_PWR_ACTIVE: begin
            if (i_cmd_strobe)
               cnt_d = 10'h000;
            else if (cnt_q != 10'(`PCCR_IDLE_CYC))
               cnt_d = cnt_q + 10'h001;
            if (want_dn || cnt_q == 10'(`PCCR_IDLE_CYC)) begin
               pwr_d = PCCR_PWR_TO_DN;
               cnt_d = 10'h000;
            end
         end
         PCCR_PWR_TO_DN: begin
            cnt_d = cnt_q + 10'h001;
            if (cnt_q == 10'(`PCCR_PWR_SETTLE_CYC - 1)) begin
               pwr_d = PCCR_PWR_DOWN;
               cnt_d = 10'h000;
            end
         end
         PCCR_PWR_DOWN: begin
            // Only a command wakes the card here; a change of the host
            // request is taken by the override after the case.
            if (i_cmd_strobe) begin
               pwr_d = PCCR_PWR_TO_UP;
               cnt_d = 10'h000;
            end
         end
         PCCR_PWR_TO_UP: begin
            cnt_d = cnt_q + 10'h001;
            if (cnt_q == 10'(`PCCR_PWR_SETTLE_CYC - 1)) begin
               pwr_d = PCCR_PWR_ACTIVE;
               cnt_d = 10'h000;
            end
         end
         default: pwr_d = PCCR_PWR_ACTIVE;
      endcase
      if (pdn_d != pdn_q) begin
         pwr_d = pdn_d ? PCCR_PWR_TO_DN : PCCR_PWR_TO_UP;
         cnt_d = 10'h000;
      end
      if (soft_rst) begin
         pwr_d = PCCR_PWR_ACTIVE;
         cnt_d = 10'h000;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pwr_q <= PCCR_PWR_ACTIVE;
         cnt_q <= 10'h000;
      end else begin
         pwr_q <= pwr_d;
         cnt_q <= cnt_d;
      end
   end

   assign rdy_int = i_drive_ready && !soft_rst &&
                    (pwr_q == PCCR_PWR_ACTIVE || pwr_q == PCCR_PWR_DOWN);

   // ----------------------------------------------------------------
   // Read data and outputs
   // ----------------------------------------------------------------
   logic [7:0] rd_d;
   logic       chg, io_cfg, irq_pend;
   logic       o_oe_d, stsn_d;

   always_comb begin
      chg = rchg_q || wchg_q;
      io_cfg = (opt_q[5:0] != 6'h00) && !soft_rst;
      irq_pend = i_drive_irq && !i_irq_enable_n;
      rd_d = 8'h00;
      if (hit(addr, `PCCR_OFF_OPTION))
         rd_d = opt_q;
      else if (hit(addr, `PCCR_OFF_STATUS)) begin
         rd_d[`PCCR_ST_CHANGED_BIT] = chg;
         rd_d[`PCCR_ST_CHANGE_SIGNAL_ENABLE_BIT] = sig_q;
         rd_d[`PCCR_ST_IO8_BIT] = io8_q;
         rd_d[`PCCR_ST_PWRDN_BIT] = pdn_q;
         rd_d[`PCCR_ST_INT_BIT] = irq_pend;
      end else if (hit(addr, `PCCR_OFF_PINREP)) begin
         rd_d = `PCCR_PR_ONES;
         rd_d[`PCCR_PR_RCHG_BIT] = rchg_q;
         rd_d[`PCCR_PR_WCHG_BIT] = wchg_q;
         rd_d[`PCCR_PR_RDY_BIT] = rdy_int;
         rd_d[`PCCR_PR_WP_BIT] = 1'b0;
      end
      o_oe_d = rd_act && !addr[0];
      stsn_d = !(io_cfg && sig_q && chg);
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_rdata_oe <= 1'b0;
         o_hard_reset <= 1'b1;
         o_level_irq_select <= 1'b0;
         o_mode <= PCCR_MODE_MEM;
         o_io_configured <= 1'b0;
         o_status_change_pin_n <= 1'b1;
         o_ready_busy <= 1'b0;
         o_powered_down <= 1'b0;
      end else begin
         o_rdata <= rd_d;
         o_rdata_oe <= o_oe_d;
         o_hard_reset <= soft_rst;
         o_level_irq_select <= opt_q[`PCCR_OPT_LEVEL_BIT];
         o_mode <= pccr_mode_e'(opt_q[1:0]);
         o_io_configured <= io_cfg;
         o_status_change_pin_n <= stsn_d;
         o_ready_busy <= rdy_int;
         o_powered_down <= (pwr_q == PCCR_PWR_DOWN);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_SRST_HARD: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      soft_rst |=> o_hard_reset) else $error("soft reset not hard");
   AST_SRST_CLR: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      soft_rst |=> !sig_q && !pdn_q) else $error("reset left state");
   AST_LEVEL: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      o_level_irq_select == $past(opt_q[6])) else $error("level sel");
   AST_MODE: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      o_mode == pccr_mode_e'($past(opt_q[1:0]))) else $error("mode");
   AST_STS_LOW: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (io_cfg && sig_q && chg) |=> !o_status_change_pin_n)
      else $error("status pin not low");
   AST_STS_HIGH: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (io_cfg && !sig_q) |=> o_status_change_pin_n)
      else $error("status pin not high");
   AST_BUSY: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (pdn_d != pdn_q && !soft_rst) |=> !rdy_int [*3])
      else $error("no busy on power change");
   AST_RCHG: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (rdy_int != rdy_prev_q && !soft_rst) |=> rchg_q)
      else $error("ready latch missed");
   AST_MASK: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (wr_pulse && hit(addr, `PCCR_OFF_PINREP) && !wdat[0] && !soft_rst)
      |=> wchg_q == $past(wchg_q)) else $error("mask ignored");
   AST_INT_OFF: assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_irq_enable_n && rd_act && hit(addr, `PCCR_OFF_STATUS))
      |=> !o_rdata[`PCCR_ST_INT_BIT]) else $error("int not gated");
endmodule

//--- tb_top.sv
// Self-checking bench for the card configuration register bank.
`include "pccr_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import pccr_pkg::*;
   logic clk, rst, reg_n, ce1_n, oe_n, we_n, oe, bsy;
   logic drq, ien_n, cmd, rd_oe, hrst, lvl, iocfg, sc_n, rdy, pdn, drdy;
   logic [9:0] addr;
   logic [7:0] wd, rdat, d;
   pccr_mode_e mode;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   pccr_host_model host (.i_core_clk(clk), .i_rdata(rdat),
      .i_rdata_oe(rd_oe), .o_reg_n(reg_n), .o_ce1_n(ce1_n),
      .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr), .o_wdata(wd));
   pccr_regs DUT (.i_core_clk(clk), .i_rst(rst), .i_reg_n(reg_n),
      .i_ce1_n(ce1_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr),
      .i_wdata(wd), .i_drive_ready(drdy), .i_drive_irq(drq),
      .i_irq_enable_n(ien_n), .i_cmd_strobe(cmd), .o_rdata(rdat),
      .o_rdata_oe(rd_oe), .o_hard_reset(hrst), .o_level_irq_select(lvl),
      .o_mode(mode), .o_io_configured(iocfg),
      .o_status_change_pin_n(sc_n), .o_ready_busy(rdy),
      .o_powered_down(pdn));
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, s, e);
      end
   endtask
   task automatic rchk(input logic [9:0] a, input logic [7:0] e);
      host.rd(a, d, oe);
      chk(d, e);
      chk({7'h00, oe}, 8'h01);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // A stuck handshake would otherwise hang the run.
   always @(posedge clk) begin
      cyc++;
      if (!rdy) bsy <= 1'b1;
      if (cyc == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      rst = 1'b1;
      {drq, ien_n, cmd, bsy, drdy} = 5'h01;
      wait_n(8);
      rst = 1'b0;
      wait_n(10);
      rchk(`PCCR_OFF_OPTION, 8'h00);
      host.wr(`PCCR_OFF_PINREP, 8'h03);
      rchk(`PCCR_OFF_STATUS, 8'h00);
      rchk(`PCCR_OFF_PINREP, 8'h0E);
      for (int i = 0; i < 4; i++) begin
         host.wr(`PCCR_OFF_OPTION, 8'h40 | 8'(i));
         chk({6'h00, mode}, 8'(i));
         chk({6'h00, iocfg, lvl}, 8'h01 | {6'h00, i != 0, 1'b0});
      end
      host.wr(`PCCR_OFF_OPTION, 8'h01);
      chk({7'h00, lvl}, 8'h00);
      host.wr(`PCCR_OFF_STATUS, 8'h60);
      rchk(`PCCR_OFF_STATUS, 8'h60);
      host.wr(`PCCR_OFF_PINREP, 8'h22);
      rchk(`PCCR_OFF_STATUS, 8'hE0);
      chk({7'h00, sc_n}, 8'h00);
      host.wr(`PCCR_OFF_STATUS, 8'h20);
      chk({7'h00, sc_n}, 8'h01);
      host.wr(`PCCR_OFF_PINREP, 8'h10);
      rchk(`PCCR_OFF_PINREP, 8'h2E);
      host.wr(`PCCR_OFF_PINREP, 8'h11);
      rchk(`PCCR_OFF_PINREP, 8'h3E);
      host.wr(`PCCR_OFF_PINREP, 8'hC3);
      rchk(`PCCR_OFF_PINREP, 8'h0E);
      drdy = 1'b0;
      rchk(`PCCR_OFF_PINREP, 8'h2C);
      chk({7'h00, rdy}, 8'h00);
      drdy = 1'b1;
      host.wr(`PCCR_OFF_PINREP, 8'h02);
      rchk(`PCCR_OFF_PINREP, 8'h0E);
      host.wr(`PCCR_OFF_STATUS, 8'h99);
      rchk(`PCCR_OFF_STATUS, 8'h00);
      drq = 1'b1;
      rchk(`PCCR_OFF_STATUS, 8'h02);
      ien_n = 1'b1;
      rchk(`PCCR_OFF_STATUS, 8'h00);
      host.wr(`PCCR_OFF_OPTION, 8'h00);
      ien_n = 1'b0;
      rchk(`PCCR_OFF_STATUS, 8'h02);
      drq = 1'b0;
      cmd = 1'b1;
      wait_n(1);
      cmd = 1'b0;
      bsy = 1'b0;
      host.wr(`PCCR_OFF_STATUS, 8'h04);
      wait_n(10);
      chk({5'h00, bsy, pdn, rdy}, 8'h07);
      rchk(`PCCR_OFF_PINREP, 8'h2E);
      bsy = 1'b0;
      host.wr(`PCCR_OFF_STATUS, 8'h00);
      wait_n(10);
      chk({5'h00, bsy, pdn, rdy}, 8'h05);
      wait_n(1010);
      chk({7'h00, pdn}, 8'h01);
      cmd = 1'b1;
      wait_n(1);
      cmd = 1'b0;
      wait_n(10);
      chk({7'h00, pdn}, 8'h00);
      host.wr(`PCCR_OFF_OPTION, 8'h81);
      wait_n(20);
      chk({6'h00, hrst, iocfg}, 8'h02);
      rchk(`PCCR_OFF_OPTION, 8'h80);
      host.wr(`PCCR_OFF_OPTION, 8'h00);
      chk({6'h00, hrst, iocfg}, 8'h00);
      rchk(`PCCR_OFF_OPTION, 8'h00);
      rchk(10'h206, 8'h00);
      host.rd(10'h201, d, oe);
      chk({7'h00, oe}, 8'h00);
      give_verdict();
   end
endmodule
